// file: dv/lcdmux_panel.sv
// panel model: records which elements each scanned row shows as lit
`timescale 1ns/1ns
module lcdmux_panel (
	// drive from the core
	input wire aclk,
	input wire [7:0] bp,
	input wire [45:0] seg,
	// rows wired to the glass, two rows cannot be told apart
	input wire [3:0] nbp,
	// element state, lit[column][row]
	output logic [7:0] lit [0:45]
);
	int same;

	// a row is scanned when its level stands apart from every other wired row
	always @(posedge aclk) begin
		for (int r = 0; r < nbp; r++) begin
			same = 0;
			for (int q = 0; q < nbp; q++)
				same += (bp[q] == bp[r]);
			if (same == 1 || nbp == 1)
				for (int c = 0; c < 46; c++)
					lit[c][r] <= seg[c] ^ bp[r];
		end
	end
endmodule

// file: dv/lcdmux_top_asserts.sv
// port checker for the lcd mux core
`timescale 1ns/1ns
module lcdmux_chk #(
	parameter PHASE_CYCLES = 1024
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bus handshakes
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	// panel drive
	input wire backplane_out_0,
	input wire backplane_out_1,
	input wire backplane_out_2,
	input wire backplane_out_3,
	input wire backplane_out_4,
	input wire backplane_out_5,
	input wire shared_seg45_backplane6,
	input wire shared_seg44_backplane7,
	input wire [43:0] segment_out,
	input wire [1:0] bias_select
);
	wire [7:0] bp = {shared_seg44_backplane7, shared_seg45_backplane6, backplane_out_5,
		backplane_out_4, backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0};
	reg [2:0] md_r;
	reg en_r;
	reg [15:0] st_r;
	reg [43:0] seg_q_r;
	reg [15:0] seg_age_r;
	// two full frames must pass after a mode write before the pins are judged
	wire ok = st_r > 16 * PHASE_CYCLES + 2;

	// mirror mode and enable; assumes address and data are taken on one edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			md_r <= 3'h0;
			en_r <= 1'h0;
			st_r <= 16'h0;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr[7:2] == 6'h0) begin
			md_r <= s_axi_wdata[2:0];
			en_r <= s_axi_wdata[16];
			st_r <= 16'h0;
		end else if (st_r != 16'hffff) begin
			st_r <= st_r + 16'h1;
		end
	end

	// cycles since the segment pins last moved; the backplane pattern alone cannot show
	// a phase boundary in 1:2 mode, so the hold is measured against the phase length
	always @(posedge aclk) begin
		seg_q_r <= segment_out;
		if (!aresetn || segment_out != seg_q_r) begin
			seg_age_r <= 16'h0;
		end else if (seg_age_r != 16'hffff) begin
			seg_age_r <= seg_age_r + 16'h1;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_MUX8_ONE: assert property (ok && en_r && md_r == 3'h4 |-> $onehot(bp) || $onehot(~bp))
		else $error("mux8 backplanes not distinct");
	AST_MUX6_ONE: assert property (ok && en_r && md_r == 3'h3 |->
		$onehot(bp[5:0]) || $onehot(~bp[5:0])) else $error("mux6 backplanes not distinct");
	AST_MUX4_REP: assert property (ok && md_r == 3'h2 |-> bp[7:4] == bp[3:0])
		else $error("mux4 repeat mismatch");
	AST_MUX2_REP: assert property (ok && md_r == 3'h1 |-> bp[7:2] == {3{bp[1:0]}})
		else $error("mux2 repeat mismatch");
	AST_STATIC_ALL: assert property (ok && md_r == 3'h0 |-> bp == {8{bp[0]}})
		else $error("static backplanes differ");
	AST_SEG_HOLD: assert property (ok && en_r && segment_out != seg_q_r |->
		seg_age_r >= PHASE_CYCLES - 1) else $error("segments moved inside a phase");
	AST_BIAS_MUX2: assert property (ok && md_r == 3'h1 |-> bias_select inside {2'h0, 2'h1})
		else $error("mux2 bias out of range");
	AST_BIAS_MUX6: assert property (ok && md_r == 3'h3 |-> bias_select inside {2'h1, 2'h2})
		else $error("mux6 bias out of range");
	AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
endmodule

bind lcdmux_top lcdmux_chk #(.PHASE_CYCLES(PHASE_CYCLES)) lcdmux_chk_i (.*);

// file: dv/lcdmux_top_test.sv
// self-checking bench for the lcd mux core
`timescale 1ns/1ns
module lcdmux_top_test;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, bias_select;
	wire [31:0] s_axi_rdata;
	wire backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3;
	wire backplane_out_4, backplane_out_5, shared_seg45_backplane6, shared_seg44_backplane7;
	wire [43:0] segment_out;
	logic [7:0] lit [0:45];
	logic [3:0] nbp = 4'h0;
	logic [1:0] wresp, rresp;
	logic [31:0] rdat;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	// pointer cases: mode, start, bytes, column, row (15 = row not checked)
	int tm[7] = '{0, 1, 2, 3, 3, 3, 4};
	int ts[7] = '{40, 0, 0, 0, 0, 45, 43};
	int tn[7] = '{2, 1, 1, 1, 2, 2, 2};
	int tc[7] = '{44, 4, 2, 1, 2, 46, 44};
	int tr[7] = '{15, 0, 0, 2, 4, 15, 15};
	// bias cases: mode, request, settled value
	int bm[6] = '{1, 1, 3, 3, 2, 4};
	int bq[6] = '{1, 2, 2, 0, 3, 0};
	int be[6] = '{1, 0, 2, 1, 2, 0};

	lcdmux_top #(.PHASE_CYCLES(8)) lcdmux_top_i (.*);
	lcdmux_panel lcdmux_panel_i (
		.aclk(aclk),
		.bp({shared_seg44_backplane7, shared_seg45_backplane6, backplane_out_5, backplane_out_4,
			backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0}),
		.seg({shared_seg45_backplane6, shared_seg44_backplane7, segment_out}),
		.nbp(nbp),
		.lit(lit)
	);

	always #4 aclk = ~aclk;

	// a hang ends the run as a failure
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim;
		end
	end

	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				wresp = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				rdat = s_axi_rdata;
				rresp = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
		end
	endtask

	function automatic logic [31:0] cw(input int m, input int b, input int i, input int o);
		return 32'(m) | 32'(b) << 4 | 32'(i) << 8 | 32'(o) << 9 | 32'h10000;
	endfunction

	// bit k of the fill stream, byte b is b*37+5, msb first
	function automatic logic pbit(input int k);
		logic [7:0] v;
		v = 8'(k / 8 * 37 + 5);
		return v[7 - k % 8];
	endfunction

	task automatic fill(input int n);
		wr(8'h04, 32'h0);
		for (int b = 0; b < n; b++)
			wr(8'h08, 32'(8'(b * 37 + 5)));
	endtask

	// switch mode, let two frames pass, then compare every scanned element
	task automatic disp(input int m, input int o, input int st, input int bs, input int rows,
		input int cols);
		wr(8'h00, cw(m, 1, 0, o));
		nbp <= 4'(rows);
		repeat (150) @(posedge aclk);
		for (int c = 0; c < cols; c++)
			for (int r = 0; r < rows; r++)
				chk("lit", 32'(pbit(c * st + bs + r)), 32'(lit[c][r]));
		$display("test display mode %0d done", m);
	endtask

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			wr(8'h00, cw(bm[i], bq[i], 0, 0));
			rd(8'h0c);
			chk("status bias", 32'(be[i]), 32'(rdat[7:6]));
			chk("bias pin", 32'(be[i]), 32'(bias_select));
		end
		rd(8'h00);
		chk("ctrl", cw(4, 0, 0, 0), rdat);
		wr(8'h10, 32'hffffffff);
		chk("bresp", 32'h2, 32'(wresp));
		rd(8'h10);
		chk("rresp", 32'h2, 32'(rresp));
		chk("rdata", 32'h0, rdat);
		$display("test registers done");
		for (int i = 0; i < 7; i++) begin
			wr(8'h00, cw(tm[i], 1, 0, 0));
			wr(8'h04, 32'(ts[i]));
			repeat (tn[i]) wr(8'h08, 32'h5a);
			rd(8'h04);
			for (int t = 0; t < 20 && rdat[16] !== 1'h0; t++)
				rd(8'h04);
			chk("ptr col", 32'(tc[i]), 32'(rdat[5:0]));
			if (tr[i] != 15)
				chk("ptr row", 32'(tr[i]), 32'(rdat[10:8]));
		end
		$display("test pointer done");
		wr(8'h00, cw(4, 1, 0, 0));
		fill(44);
		disp(4, 0, 8, 0, 8, 44);
		disp(2, 0, 8, 0, 4, 44);
		disp(2, 1, 8, 4, 4, 44);
		disp(0, 1, 8, 4, 1, 44);
		// input bank 1 in 1:4 mode: one byte lands in rows 4..7 of columns 0 and 1
		wr(8'h00, cw(2, 1, 1, 1));
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h3c);
		nbp <= 4'h4;
		repeat (150) @(posedge aclk);
		for (int r = 0; r < 8; r++)
			chk("in bank", (32'h3c >> (7 - r)) & 32'h1, 32'(lit[r / 4][r % 4]));
		$display("test input bank done");
		disp(1, 0, 8, 0, 0, 0);
		wr(8'h00, cw(3, 1, 0, 0));
		fill(35);
		disp(3, 0, 6, 0, 6, 46);
		end_sim;
	end
endmodule

// file: hdl/lcdmux_bp_map.v
// backplane phase mapper: active phase and mode to the eight backplane levels
`timescale 1ns/1ns
`include "lcdmux_defines.vh"

module lcdmux_bp_map (
	// mode and timing
	input wire [2:0] mode,
	input wire [2:0] phase,
	input wire invert,
	// backplane levels, 1 = select level before inversion
	output reg [7:0] bp
);

	integer k;

	// each output compares its own index folded by the phase count
	always @* begin
		bp = 8'h00;
		for (k = 0; k < 8; k = k + 1) begin
			case (mode)
				`LCDMUX_MODE_MUX8: bp[k] = (phase == k[2:0]);
				`LCDMUX_MODE_MUX6: bp[k] = (k < 6) && (phase == k[2:0]);
				`LCDMUX_MODE_MUX4: bp[k] = (phase[1:0] == k[1:0]);
				`LCDMUX_MODE_MUX2: bp[k] = (phase[0] == k[0]);
				default: bp[k] = 1'b1;
			endcase
			bp[k] = bp[k] ^ invert;
		end
	end

endmodule

// file: hdl/lcdmux_defines.vh
// register map, field positions, mode codes and timing counts of the lcd mux core
`ifndef LCDMUX_DEFINES_VH
`define LCDMUX_DEFINES_VH

// register word offsets, address bits 7:2
`define LCDMUX_OFF_CTRL 6'h00
`define LCDMUX_OFF_PTR 6'h01
`define LCDMUX_OFF_DATA 6'h02
`define LCDMUX_OFF_STAT 6'h03

// control register fields
`define LCDMUX_CTRL_MODE_LSB 0
`define LCDMUX_CTRL_BIAS_LSB 4
`define LCDMUX_CTRL_IBS 8
`define LCDMUX_CTRL_OBS 9
`define LCDMUX_CTRL_EN 16
`define LCDMUX_CTRL_RESET 32'h00000000

// mux mode codes
`define LCDMUX_MODE_STATIC 3'h0
`define LCDMUX_MODE_MUX2 3'h1
`define LCDMUX_MODE_MUX4 3'h2
`define LCDMUX_MODE_MUX6 3'h3
`define LCDMUX_MODE_MUX8 3'h4

// bias codes
`define LCDMUX_BIAS_HALF 2'h0
`define LCDMUX_BIAS_THIRD 2'h1
`define LCDMUX_BIAS_QUARTER 2'h2
`define LCDMUX_BIAS_STATIC 2'h3

// ram geometry
`define LCDMUX_COLS_STD 6'h2c
`define LCDMUX_COLS_MUX6 6'h2e
`define LCDMUX_BANK1_ROW 3'h4

// timing: clock cycles per backplane phase
`define LCDMUX_PHASE_CYCLES 1024

// axi answers
`define LCDMUX_RESP_OKAY 2'h0
`define LCDMUX_RESP_SLVERR 2'h2

`endif

// file: hdl/lcdmux_top.v
// lcd mux core: display ram, byte filling, display register, backplane and segment drive
// How it works
// - 1:8 mode drives eight distinct backplanes, shared pins as backplanes six and seven.
// - 1:6 mode drives six backplanes; shared pins become segments 44 and 45.
// - 1:4 mode repeats backplanes 0..3 on outputs 4..7.
// - 1:2 mode repeats phase 0 on even outputs, phase 1 on odd.
// - static mode drives the same signal on all eight backplanes.
// - segments 0..43 always drive; 44 and 45 only in 1:6 mode.
// - segment level comes from frame polarity and the display register bit.
// - 1:2 mode offers half or third bias.
// - 1:6 mode offers third or quarter bias.
// - ram is 44x8 in 1:8, 46x6 in 1:6, no banks.
// - 4-, 2-, 1-row modes use 44 columns in two selectable banks.
// - a ram one turns the element on, a zero turns it off.
// - ram rows map to backplanes, ram columns to segments, row with backplane.
// - a display register holds the row while its phase is output.
// - the controller keeps settings and fills ram in mode order.
// - each byte is stored one bit per cycle in bits, pairs, quads, sextets or bytes.
// - pointer advances 8, 4, 2, 1 or 2, or 1 columns per byte.
// - pointer stops at row end; surplus bits and bytes are dropped.
// - input and output banks are chosen independently.
`timescale 1ns/1ns
`include "lcdmux_defines.vh"

module lcdmux_top #(
	parameter PHASE_CYCLES = `LCDMUX_PHASE_CYCLES
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// backplane drive
	output reg backplane_out_0,
	output reg backplane_out_1,
	output reg backplane_out_2,
	output reg backplane_out_3,
	output reg backplane_out_4,
	output reg backplane_out_5,
	output reg shared_seg45_backplane6,
	output reg shared_seg44_backplane7,
	// segment drive, bit 0 is segment_out_first, bit 43 segment_out_last_fixed
	output reg [43:0] segment_out,
	// bias selection handed to the voltage selector
	output reg [1:0] bias_select
);

	// write walker states
	localparam W_IDLE = 2'b01;
	localparam W_BITS = 2'b10;

	// settings
	reg [31:0] ctrl_r;
	wire [2:0] mode = ctrl_r[`LCDMUX_CTRL_MODE_LSB +: 3];
	wire [1:0] bias_req = ctrl_r[`LCDMUX_CTRL_BIAS_LSB +: 2];
	wire input_bank_select = ctrl_r[`LCDMUX_CTRL_IBS];
	wire output_bank_select = ctrl_r[`LCDMUX_CTRL_OBS];
	wire enable = ctrl_r[`LCDMUX_CTRL_EN];

	// display ram: one word per column, bit index is the row
	reg [7:0] ram [0:45];

	// data pointer and walker
	reg [5:0] ptr_col_r;
	reg [2:0] ptr_row_r;
	reg [1:0] wstate_r;
	reg [2:0] bitcnt_r;
	reg [7:0] byte_r;

	// axi holding registers
	reg aw_held_r;
	reg w_held_r;
	reg [5:0] waddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;

	// frame timing and display register
	reg [12:0] tick_r;
	reg [2:0] phase_r;
	reg invert_r;
	reg [45:0] disp_r;
	reg [45:0] disp_nxt;
	wire [7:0] bp_level;

	// per-mode geometry
	reg [3:0] rows_per_col;
	reg [5:0] col_limit;
	reg [2:0] in_base;
	reg [2:0] out_base;
	reg [1:0] bias_nxt;
	integer c;
	// separate loop index so the combinational gather does not share a driver with the reset loop
	integer j;

	// rows per column, column count and bank base rows for the active mode
	always @* begin
		col_limit = `LCDMUX_COLS_STD;
		in_base = 3'h0;
		out_base = 3'h0;
		case (mode)
			`LCDMUX_MODE_MUX8: rows_per_col = 4'h8;
			`LCDMUX_MODE_MUX6: begin
				rows_per_col = 4'h6;
				col_limit = `LCDMUX_COLS_MUX6;
			end
			`LCDMUX_MODE_MUX4: rows_per_col = 4'h4;
			`LCDMUX_MODE_MUX2: rows_per_col = 4'h2;
			default: rows_per_col = 4'h1;
		endcase
		// banks exist only where one bank leaves at least half the rows free
		if (rows_per_col <= 4'h4) begin
			in_base = input_bank_select ? `LCDMUX_BANK1_ROW : 3'h0;
			out_base = output_bank_select ? `LCDMUX_BANK1_ROW : 3'h0;
		end
	end

	// clamp the requested bias to what the mode offers
	always @* begin
		case (mode)
			`LCDMUX_MODE_MUX2:
				bias_nxt = (bias_req == `LCDMUX_BIAS_THIRD) ? `LCDMUX_BIAS_THIRD :
					`LCDMUX_BIAS_HALF;
			`LCDMUX_MODE_MUX6:
				bias_nxt = (bias_req == `LCDMUX_BIAS_QUARTER) ? `LCDMUX_BIAS_QUARTER :
					`LCDMUX_BIAS_THIRD;
			`LCDMUX_MODE_STATIC: bias_nxt = `LCDMUX_BIAS_STATIC;
			default: bias_nxt = (bias_req == `LCDMUX_BIAS_STATIC) ? `LCDMUX_BIAS_QUARTER :
				bias_req;
		endcase
	end

	// axi decode helpers
	wire do_write = aw_held_r && w_held_r && !s_axi_bvalid && (wstate_r == W_IDLE);
	wire wr_ctrl = waddr_r == `LCDMUX_OFF_CTRL;
	wire wr_ptr = waddr_r == `LCDMUX_OFF_PTR;
	wire wr_data = waddr_r == `LCDMUX_OFF_DATA;
	wire wr_stat = waddr_r == `LCDMUX_OFF_STAT;
	wire wr_known = wr_ctrl || wr_ptr || wr_data || wr_stat;
	wire at_end = ptr_col_r >= col_limit;

	// write address and data are caught independently, in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= 6'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LCDMUX_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				waddr_r <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			// a write waits while the walker still stores the previous byte
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `LCDMUX_RESP_OKAY : `LCDMUX_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// settings register, pointer load and byte walker
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `LCDMUX_CTRL_RESET;
			ptr_col_r <= 6'h00;
			ptr_row_r <= 3'h0;
			wstate_r <= W_IDLE;
			bitcnt_r <= 3'h0;
			byte_r <= 8'h00;
			for (c = 0; c < 46; c = c + 1) begin
				ram[c] <= 8'h00;
			end
		end else begin
			case (wstate_r)
				W_IDLE: begin
					if (do_write && wr_ctrl) begin
						if (wstrb_r[0]) begin
							ctrl_r[7:0] <= wdata_r[7:0] & 8'h37;
						end
						if (wstrb_r[1]) begin
							ctrl_r[15:8] <= wdata_r[15:8] & 8'h03;
						end
						if (wstrb_r[2]) begin
							ctrl_r[23:16] <= wdata_r[23:16] & 8'h01;
						end
					end
					// reloading the pointer always restarts at row 0 of the column
					if (do_write && wr_ptr && wstrb_r[0]) begin
						ptr_col_r <= wdata_r[5:0];
						ptr_row_r <= 3'h0;
					end
					if (do_write && wr_data && wstrb_r[0]) begin
						byte_r <= wdata_r[7:0];
						bitcnt_r <= 3'h0;
						wstate_r <= W_BITS;
					end
				end
				W_BITS: begin
					// one bit per cycle, msb first, down the rows of a column then across
					if (!at_end) begin
						ram[ptr_col_r][in_base + ptr_row_r] <= byte_r[3'h7 - bitcnt_r];
						if ({1'b0, ptr_row_r} == rows_per_col - 4'h1) begin
							ptr_row_r <= 3'h0;
							ptr_col_r <= ptr_col_r + 6'h01;
						end else begin
							ptr_row_r <= ptr_row_r + 3'h1;
						end
					end
					bitcnt_r <= bitcnt_r + 3'h1;
					if (bitcnt_r == 3'h7) begin
						wstate_r <= W_IDLE;
					end
				end
				default: wstate_r <= W_IDLE;
			endcase
		end
	end

	// read channel: one read at a time, answer one edge after the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LCDMUX_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `LCDMUX_RESP_OKAY;
				case (s_axi_araddr[7:2])
					`LCDMUX_OFF_CTRL: s_axi_rdata <= ctrl_r;
					`LCDMUX_OFF_PTR: s_axi_rdata <= {15'h0000, wstate_r == W_BITS,
						5'h00, ptr_row_r, 2'h0, ptr_col_r};
					`LCDMUX_OFF_DATA: s_axi_rdata <= {24'h000000, byte_r};
					`LCDMUX_OFF_STAT: s_axi_rdata <= {24'h000000, bias_select, 1'b0,
						at_end, invert_r, phase_r};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `LCDMUX_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// row of the next phase, gathered across all columns
	wire last_phase = ({1'b0, phase_r} >= rows_per_col - 4'h1);
	wire [2:0] phase_nxt = last_phase ? 3'h0 : phase_r + 3'h1;
	always @* begin
		disp_nxt = 46'h0;
		for (j = 0; j < 46; j = j + 1) begin
			disp_nxt[j] = ram[j][out_base + phase_nxt];
		end
	end

	// phase timer; the display register is reloaded only at a phase boundary
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_r <= 13'h0000;
			phase_r <= 3'h0;
			invert_r <= 1'b0;
			disp_r <= 46'h0;
		end else if (tick_r == PHASE_CYCLES[12:0] - 13'h0001) begin
			tick_r <= 13'h0000;
			phase_r <= phase_nxt;
			disp_r <= disp_nxt;
			// polarity flips each frame so the panel sees no dc
			if (last_phase) begin
				invert_r <= ~invert_r;
			end
		end else begin
			tick_r <= tick_r + 13'h0001;
		end
	end

	// backplane mapping for the current phase
	lcdmux_bp_map u_bp_map (
		.mode(mode),
		.phase(phase_r),
		.invert(invert_r),
		.bp(bp_level)
	);

	// output stage: every pin registered on the same edge, backplanes and segments off while disabled
	always @(posedge aclk) begin
		if (!aresetn || !enable) begin
			backplane_out_0 <= 1'b0;
			backplane_out_1 <= 1'b0;
			backplane_out_2 <= 1'b0;
			backplane_out_3 <= 1'b0;
			backplane_out_4 <= 1'b0;
			backplane_out_5 <= 1'b0;
			shared_seg45_backplane6 <= 1'b0;
			shared_seg44_backplane7 <= 1'b0;
			segment_out <= 44'h0;
			bias_select <= aresetn ? bias_nxt : `LCDMUX_BIAS_STATIC;
		end else begin
			// repeats come from one mapper vector, so pairs never disagree
			backplane_out_0 <= bp_level[0];
			backplane_out_1 <= bp_level[1];
			backplane_out_2 <= bp_level[2];
			backplane_out_3 <= bp_level[3];
			backplane_out_4 <= bp_level[4];
			backplane_out_5 <= bp_level[5];
			// an on element drives opposite to the selected backplane
			segment_out <= disp_r[43:0] ^ {44{~invert_r}};
			if (mode == `LCDMUX_MODE_MUX6) begin
				shared_seg45_backplane6 <= disp_r[45] ^ ~invert_r;
				shared_seg44_backplane7 <= disp_r[44] ^ ~invert_r;
			end else begin
				shared_seg45_backplane6 <= bp_level[6];
				shared_seg44_backplane7 <= bp_level[7];
			end
			bias_select <= bias_nxt;
		end
	end

endmodule
